// ==== hw/cbu_pkg.sv ====
// Package: opcodes, conditions, register map and reset values
package cbu_pkg;

  // Instruction numbers
  localparam logic [7:0] CBU_OP_ARITH  = 8'h13; // arithmetic_instr (19)
  localparam logic [7:0] CBU_OP_TEST   = 8'h14; // accumulator test (20)
  localparam logic [7:0] CBU_OP_CBR    = 8'h15; // conditional_branch_instr (21)
  localparam logic [7:0] CBU_OP_UBR    = 8'h16; // unconditional_branch_instr (22)
  localparam logic [7:0] CBU_OP_WAIT   = 8'h1b; // wait instruction (27)

  // Conditional branch type codes
  localparam logic [7:0] CBU_NULL_RESULT_COND    = 8'h00;
  localparam logic [7:0] CBU_NONNULL_RESULT_COND = 8'h01;
  localparam logic [7:0] CBU_SAME_VALUE_COND     = 8'h02;
  localparam logic [7:0] CBU_DIFFER_COND         = 8'h03;
  localparam logic [7:0] CBU_ABOVE_COND          = 8'h04;
  localparam logic [7:0] CBU_ABOVE_OR_SAME_COND  = 8'h05;
  localparam logic [7:0] CBU_BELOW_COND          = 8'h06;
  localparam logic [7:0] CBU_BELOW_OR_SAME_COND  = 8'h07;
  localparam logic [7:0] CBU_TIMEOUT_ERROR_COND  = 8'h08;
  localparam logic [7:0] CBU_EXTERNAL_ALARM_COND = 8'h09;
  localparam logic [7:0] CBU_DEVIATION_ERROR_COND = 8'h0a;
  localparam logic [7:0] CBU_POSITION_ERROR_COND = 8'h0b;

  // Arithmetic sub-operations handled here
  localparam logic [7:0] CBU_ARITH_ADD  = 8'h00;
  localparam logic [7:0] CBU_ARITH_SUB  = 8'h01;
  localparam logic [7:0] CBU_ARITH_AND  = 8'h05;
  localparam logic [7:0] CBU_ARITH_OR   = 8'h06;
  localparam logic [7:0] CBU_ARITH_XOR  = 8'h07;
  localparam logic [7:0] CBU_ARITH_NOT  = 8'h08;
  localparam logic [7:0] CBU_ARITH_LOAD = 8'h09;

  // Register byte offsets
  localparam logic [7:0] CBU_REG_CTRL   = 8'h00; // Bit0 run, bit1 load pc
  localparam logic [7:0] CBU_REG_START  = 8'h04; // Start address
  localparam logic [7:0] CBU_REG_PC     = 8'h08; // Program counter, ro
  localparam logic [7:0] CBU_REG_ACC    = 8'h0c; // Accumulator, ro
  localparam logic [7:0] CBU_REG_FLAGS  = 8'h10; // Status flags, ro
  localparam logic [7:0] CBU_REG_IRQST  = 8'h14; // Sticky events, w1c
  localparam logic [7:0] CBU_REG_IRQMSK = 8'h18; // Event mask
  localparam logic [7:0] CBU_REG_ERRCLR = 8'h1c; // Write one clears error

  // Field positions
  localparam int CBU_CTRL_RUN_BIT  = 0;
  localparam int CBU_CTRL_LOAD_BIT = 1;
  localparam int CBU_EV_TEST_BIT   = 0; // Test executed
  localparam int CBU_EV_TAKEN_BIT  = 1; // Branch taken
  localparam int CBU_EV_TMO_BIT    = 2; // Timeout flag raised
  localparam int CBU_EV_BAD_BIT    = 3; // Unknown condition code
  localparam int CBU_EV_W          = 4;

  // Reset values
  localparam logic [31:0] CBU_ACC_RST  = 32'h0000_0000;
  localparam logic [3:0]  CBU_MASK_RST = 4'h0;

  // AXI responses
  localparam logic [1:0] CBU_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CBU_RESP_SLVERR = 2'b10;

  // Sequencer states
  typedef enum logic [1:0] {
    CBU_IDLE,
    CBU_FETCH,
    CBU_EXEC
  } cbu_state_t;

endpackage : cbu_pkg

// ==== hw/cbu_prog_mem.sv ====
// Program memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module cbu_prog_mem #(
  parameter int AW = 8,  // Address width
  parameter int DW = 48  // Instruction word width
) (
  input  wire logic          aclk,    // Clock
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [DW-1:0] wdata,   // Write data
  input  wire logic [AW-1:0] raddr,   // Read address
  output var  logic [DW-1:0] rdata    // Registered read data
);

  logic [DW-1:0] mem [2**AW]; // Storage, no reset needed

  // One write and one registered read per cycle
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : cbu_prog_mem
`default_nettype wire

// ==== hw/cbu_cond_eval.sv ====
// Branch condition decoder over comparison and error flags
`timescale 1ns/1ps
`default_nettype none
module cbu_cond_eval
  import cbu_pkg::*;
(
  input  wire logic [7:0] cond,      // Type field of the branch
  input  wire logic       flag_zero, // Test result was zero (accumulator equalled operand)
  input  wire logic       flag_eq,   // Accumulator equalled operand
  input  wire logic       flag_gt,   // Accumulator above operand
  input  wire logic       err_tmo,   // Timeout error
  input  wire logic       err_alarm, // External alarm
  input  wire logic       err_dev,   // Deviation error
  input  wire logic       err_pos,   // Position error
  output var  logic       hold,      // Condition true
  output var  logic       bad        // Code not defined
);

  // Stored test flags, stored timeout flag and live alarm, deviation and position inputs, no new compare here (see RULE_06)
  always_comb begin
    hold = 1'b0;
    bad  = 1'b0;
    case (cond)
      CBU_NULL_RESULT_COND:     hold = flag_zero;            // see RULE_04
      CBU_NONNULL_RESULT_COND:  hold = !flag_zero;           // see RULE_04
      CBU_SAME_VALUE_COND:      hold = flag_eq;              // see RULE_04
      CBU_DIFFER_COND:          hold = !flag_eq;             // see RULE_04
      CBU_ABOVE_COND:           hold = flag_gt;              // see RULE_04
      CBU_ABOVE_OR_SAME_COND:   hold = flag_gt || flag_eq;   // see RULE_04
      CBU_BELOW_COND:           hold = !flag_gt && !flag_eq; // see RULE_04
      CBU_BELOW_OR_SAME_COND:   hold = !flag_gt;             // see RULE_04
      CBU_TIMEOUT_ERROR_COND:   hold = err_tmo;              // see RULE_05
      CBU_EXTERNAL_ALARM_COND:  hold = err_alarm;            // see RULE_05
      CBU_DEVIATION_ERROR_COND: hold = err_dev;              // see RULE_05
      CBU_POSITION_ERROR_COND:  hold = err_pos;              // see RULE_05
      default:                  bad  = 1'b1; // Falls through untaken
    endcase
  end

endmodule : cbu_cond_eval
`default_nettype wire

// ==== hw/cbu_top.sv ====
// Compare-and-branch sequencer with AXI4-Lite register slave
//
// Functional notes
// (RULE_01) Test 20 compares accumulator, accumulator unchanged
// (RULE_02) Test updates flags used by later branches
// (RULE_03) Branch 21 loads pc when condition holds
// (RULE_04) Codes 0..7 select comparison conditions
// (RULE_05) Codes 8..11 test error flags instead
// (RULE_06) Branch uses flags of latest test
// (RULE_07) Branch 22 always loads pc
// (RULE_08) Issuer uses these from stored program only
// (RULE_09) Arithmetic result written back to accumulator
// (RULE_10) Wait timeout sets timeout error flag
// (RULE_11) False condition just advances pc
// (RULE_12) Operand 32-bit signed, msb first; signed compare
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cbu_top
  import cbu_pkg::*;
#(
  parameter int PC_W = 8 // Program counter width
) (
  input  wire logic            aclk,          // Clock, 40 MHz
  input  wire logic            aresetn,       // Sync reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output var  logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output var  logic            s_axi_wready,
  output var  logic [1:0]      s_axi_bresp,
  output var  logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output var  logic            s_axi_arready,
  output var  logic [31:0]     s_axi_rdata,
  output var  logic [1:0]      s_axi_rresp,
  output var  logic            s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Program load port
  input  wire logic            prog_we,       // Write one instruction
  input  wire logic [PC_W-1:0] prog_addr,     // Its address
  input  wire logic [47:0]     prog_data,     // Op, type, value
  // Error sources from the rest of the interpreter
  input  wire logic            wait_timeout,  // Wait hit its limit, pulse
  input  wire logic            ext_alarm,     // External alarm level
  input  wire logic            dev_error,     // Deviation error level
  input  wire logic            pos_error,     // Position error level
  // Status outputs
  output var  logic [PC_W-1:0] pc,            // Program counter
  output var  logic [31:0]     accu,          // Accumulator
  output var  logic            running,       // Sequencer active
  output var  logic            irq            // Level interrupt
);

  // Whole state of the block
  typedef struct packed {
    cbu_state_t      st;        // Sequencer state
    logic [PC_W-1:0] pc;        // Program counter
    logic [31:0]     accu;      // Accumulator
    logic            f_zero;    // Flags from latest test
    logic            f_eq;
    logic            f_gt;
    logic            e_tmo;     // Timeout error flag
    logic            run;       // Run enable
    logic [PC_W-1:0] start;     // Start address
    logic [CBU_EV_W-1:0] ev;    // Sticky events
    logic [CBU_EV_W-1:0] mask;  // Event mask
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            irq;
  } cbu_state_s_t;

  cbu_state_s_t r;       // Registered state
  cbu_state_s_t next_r;  // Next state

  logic [47:0]     instr;     // Fetched instruction
  logic            cond_hold; // Branch condition true
  logic            cond_bad;  // Undefined condition code
  logic [7:0]      op;        // Instruction number
  logic [7:0]      typ;       // Type field
  logic [31:0]     val;       // Value field, msb first

  // Field split: byte 3 of value arrives first (see RULE_12)
  assign op  = instr[47:40];
  assign typ = instr[39:32];
  assign val = instr[31:0];

  // Stored program
  cbu_prog_mem #(
    .AW (PC_W),
    .DW (48)
  ) u_mem (
    .aclk  (aclk),
    .we    (prog_we),
    .waddr (prog_addr),
    .wdata (prog_data),
    .raddr (r.pc),
    .rdata (instr)
  );

  // Condition decode
  cbu_cond_eval u_cond (
    .cond      (typ),
    .flag_zero (r.f_zero),
    .flag_eq   (r.f_eq),
    .flag_gt   (r.f_gt),
    .err_tmo   (r.e_tmo),
    .err_alarm (ext_alarm),
    .err_dev   (dev_error),
    .err_pos   (pos_error),
    .hold      (cond_hold),
    .bad       (cond_bad)
  );

  // Next state: sequencer, arithmetic, flags and bus slave
  always_comb begin
    logic [CBU_EV_W-1:0] ev_set;  // Events this cycle
    logic [CBU_EV_W-1:0] ev_clr;  // Software clears
    logic                wr_go;   // Write address and data present
    logic                clr_err; // Software clears timeout flag
    logic [7:0]          wa;      // Write address
    ev_set  = '0;
    ev_clr  = '0;
    clr_err = 1'b0;
    wa      = s_axi_awaddr;
    next_r  = r;
    wr_go   = s_axi_awvalid && s_axi_wvalid && !r.bvalid;

    // Sequencer; the program is the only issuer (see RULE_08)
    case (r.st)
      CBU_IDLE: begin
        if (r.run) begin
          next_r.st = CBU_FETCH;
        end
      end
      CBU_FETCH: begin
        // Memory read of r.pc lands this cycle
        next_r.st = CBU_EXEC;
      end
      CBU_EXEC: begin
        next_r.st = r.run ? CBU_FETCH : CBU_IDLE;
        next_r.pc = r.pc + 1'b1; // Default advance (see RULE_11)
        case (op)
          CBU_OP_TEST: begin
            // Signed compare, accumulator left alone (see RULE_01)
            next_r.f_eq   = (r.accu == val);                    // see RULE_02
            next_r.f_gt   = ($signed(r.accu) > $signed(val));   // see RULE_12
            next_r.f_zero = (r.accu == val);                    // see RULE_02
            ev_set[CBU_EV_TEST_BIT] = 1'b1;
          end
          CBU_OP_CBR: begin
            if (cond_hold) begin
              next_r.pc = val[PC_W-1:0];                        // see RULE_03
              ev_set[CBU_EV_TAKEN_BIT] = 1'b1;
            end
            ev_set[CBU_EV_BAD_BIT] = cond_bad; // Untaken, flagged
          end
          CBU_OP_UBR: begin
            next_r.pc = val[PC_W-1:0];                          // see RULE_07
            ev_set[CBU_EV_TAKEN_BIT] = 1'b1;
          end
          CBU_OP_ARITH: begin
            // Result back to accumulator (see RULE_09)
            case (typ)
              CBU_ARITH_ADD:  next_r.accu = r.accu + val;
              CBU_ARITH_SUB:  next_r.accu = r.accu - val;
              CBU_ARITH_AND:  next_r.accu = r.accu & val;
              CBU_ARITH_OR:   next_r.accu = r.accu | val;
              CBU_ARITH_XOR:  next_r.accu = r.accu ^ val;
              CBU_ARITH_NOT:  next_r.accu = ~r.accu;
              CBU_ARITH_LOAD: next_r.accu = val;
              default:        next_r.accu = r.accu; // Done elsewhere
            endcase
          end
          default: begin
            // Other instructions belong to other units
          end
        endcase
      end
      default: next_r.st = CBU_IDLE;
    endcase

    // Write channel: both address and data taken together
    next_r.awready = 1'b0;
    next_r.wready  = 1'b0;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_go && !r.awready) begin
      next_r.awready = 1'b1;
      next_r.wready  = 1'b1;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = CBU_RESP_OKAY;
      case (wa)
        CBU_REG_CTRL: begin
          if (s_axi_wstrb[0]) begin
            next_r.run = s_axi_wdata[CBU_CTRL_RUN_BIT];
            if (s_axi_wdata[CBU_CTRL_LOAD_BIT]) begin
              next_r.pc = r.start;
            end
          end
        end
        CBU_REG_START: begin
          if (s_axi_wstrb[0]) begin
            next_r.start = s_axi_wdata[PC_W-1:0];
          end
        end
        CBU_REG_IRQST: begin
          if (s_axi_wstrb[0]) begin
            ev_clr = s_axi_wdata[CBU_EV_W-1:0];
          end
        end
        CBU_REG_IRQMSK: begin
          if (s_axi_wstrb[0]) begin
            next_r.mask = s_axi_wdata[CBU_EV_W-1:0];
          end
        end
        CBU_REG_ERRCLR: begin
          clr_err = s_axi_wstrb[0] && s_axi_wdata[0];
        end
        CBU_REG_PC, CBU_REG_ACC, CBU_REG_FLAGS: begin
          // Read-only, write ignored
        end
        default: next_r.bresp = CBU_RESP_SLVERR;
      endcase
    end

    // Timeout error: set wins over clear (see RULE_10)
    if (clr_err) begin
      next_r.e_tmo = 1'b0;
    end
    if (wait_timeout) begin
      next_r.e_tmo = 1'b1;                                      // see RULE_10
      ev_set[CBU_EV_TMO_BIT] = 1'b1;
    end

    // Sticky events: set wins over write-one clear
    next_r.ev = (r.ev & ~ev_clr) | ev_set;

    // Read channel
    next_r.arready = 1'b0;
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid && !r.arready) begin
      next_r.arready = 1'b1;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = CBU_RESP_OKAY;
      next_r.rdata   = '0;
      case (s_axi_araddr)
        CBU_REG_CTRL:   next_r.rdata[CBU_CTRL_RUN_BIT] = r.run;
        CBU_REG_START:  next_r.rdata[PC_W-1:0] = r.start;
        CBU_REG_PC:     next_r.rdata[PC_W-1:0] = r.pc;
        CBU_REG_ACC:    next_r.rdata = r.accu;
        CBU_REG_FLAGS:  next_r.rdata[3:0] = {r.e_tmo, r.f_gt, r.f_eq,
                                             r.f_zero};
        CBU_REG_IRQST:  next_r.rdata[CBU_EV_W-1:0] = r.ev;
        CBU_REG_IRQMSK: next_r.rdata[CBU_EV_W-1:0] = r.mask;
        CBU_REG_ERRCLR: next_r.rdata = '0;
        default:        next_r.rresp = CBU_RESP_SLVERR;
      endcase
    end

    // Level interrupt from next-state status, registered with it
    next_r.irq = |(next_r.ev & next_r.mask);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r       <= '0;
      r.st    <= CBU_IDLE;
      r.accu  <= CBU_ACC_RST;
      r.mask  <= CBU_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = r.awready;
  assign s_axi_wready  = r.wready;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign pc            = r.pc;
  assign accu          = r.accu;
  assign running       = r.run;
  assign irq           = r.irq;

endmodule : cbu_top
`default_nettype wire

// ==== sim/cbu_monitor.sv ====
// Checker: bus answers and program sequencing seen at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module cbu_monitor
  import cbu_pkg::*;
#(
  parameter int PC_W = 8 // Program counter width
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [7:0]      s_axi_araddr,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic            prog_we,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [47:0]     prog_data,
  input wire logic [PC_W-1:0] pc,
  input wire logic [31:0]     accu,
  input wire logic            running
);
  logic [47:0]     shadow [2**PC_W]; // Copy of program memory
  logic [PC_W-1:0] last_pc;          // Pc one edge ago
  logic [47:0]     ins;              // Instruction just finished
  // Shadow copy lets the checker decode what ran without peeking inside
  always_ff @(posedge aclk) begin
    if (prog_we) shadow[prog_addr] <= prog_data;
    last_pc <= pc;
  end
  assign ins = shadow[last_pc];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pc moved on while running, after executing opcode op
  sequence s_exec(op);
    running && $past(running) && pc != last_pc && ins[47:40] == op;
  endsequence
  property p_wr_ans;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=>
      s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  property p_rd_ans;
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_unmap;
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 8'h1c |=>
      s_axi_rresp == CBU_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_test;
    s_exec(CBU_OP_TEST) |-> pc == last_pc + 1'b1 && $stable(accu);
  endproperty
  property p_load;
    s_exec(CBU_OP_ARITH) ##0 ins[39:32] == CBU_ARITH_LOAD |->
      accu == ins[31:0];
  endproperty
  property p_cbr;
    s_exec(CBU_OP_CBR) |-> pc == ins[PC_W-1:0] || pc == last_pc + 1'b1;
  endproperty
  property p_cbr_bad;
    s_exec(CBU_OP_CBR) ##0 ins[39:32] > 8'h0b |-> pc == last_pc + 1'b1;
  endproperty
  property p_ubr;
    s_exec(CBU_OP_UBR) |-> pc == ins[PC_W-1:0];
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
  a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read ok");
  a_test: assert property (p_test)
    else $error("test moved accu");
  a_load: assert property (p_load)
    else $error("accu not loaded");
  a_cbr: assert property (p_cbr) else $error("branch pc wrong");
  a_cbr_bad: assert property (p_cbr_bad)
    else $error("bad code taken");
  a_ubr: assert property (p_ubr) else $error("jump pc wrong");
endmodule : cbu_monitor
bind cbu_top cbu_monitor #(.PC_W(PC_W)) cbu_monitor_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_we,
  .prog_addr, .prog_data, .pc, .accu, .running);
`default_nettype wire

// ==== sim/cbu_prog_host.sv ====
// Stored-program model: writes instruction words into program memory
`timescale 1ns/1ps
`default_nettype none
module cbu_prog_host (
  input  wire logic        aclk,      // Clock
  output var  logic        prog_we,   // Write strobe
  output var  logic [7:0]  prog_addr, // Instruction address
  output var  logic [47:0] prog_data  // Instruction word
);
  // Idle bus at time zero
  initial begin
    prog_we = 1'b0;
    prog_addr = 8'h00;
    prog_data = 48'h0;
  end
  // Test and branches only ever arrive as stored words
  task automatic put(input logic [7:0] a, op, ty, input logic [31:0] v);
    @(posedge aclk);
    prog_we   <= 1'b1;
    prog_addr <= a;
    prog_data <= {op, ty, v[31:24], v[23:16], v[15:8], v[7:0]};
    @(posedge aclk);
    prog_we   <= 1'b0;
    prog_data <= ~prog_data; // Released: never leave a stale word behind
  endtask : put
endmodule : cbu_prog_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the compare-and-branch unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin logic [33:0] e_; e_ = (exp); n_compared++; \
  if ((got) !== e_) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e_); end end
module tb_top
  import cbu_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, wait_timeout, ext_alarm;
  logic        dev_error, pos_error, s_axi_awready, s_axi_wready, prog_we;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, running, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pc, prog_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, accu;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [47:0] prog_data;
  int          bad_count, n_compared, cyc;
  logic [33:0] exp_q[$];               // Expected {resp, data} per answer
  logic [31:0] seed = 32'h79da234d;    // Xorshift state
  // Free-running 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  cbu_top cbu_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_data(prog_data), .wait_timeout(wait_timeout),
    .ext_alarm(ext_alarm), .dev_error(dev_error), .pos_error(pos_error),
    .pc(pc), .accu(accu), .running(running), .irq(irq));
  cbu_prog_host cbu_prog_host_i (.aclk(aclk), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Branch outcome from the last test's operands and the error levels
  function automatic logic taken(input int c, input logic [31:0] a, b,
                                 input logic e);
    case (c)
      0, 2: return a == b;
      1, 3: return a != b;
      4: return $signed(a) > $signed(b);
      5: return $signed(a) >= $signed(b);
      6: return $signed(a) < $signed(b);
      7: return $signed(a) <= $signed(b);
      8, 9, 10, 11: return e;
      default: return 1'b0;
    endcase
  endfunction : taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    exp_q.push_back({er, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_wdata <= ~d;
    s_axi_bready <= 1'b1; // Late on purpose: response must stand meanwhile
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    exp_q.push_back({er, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // Answer watcher: oldest note against each completed response
  always @(posedge aclk) begin
    // Each note is popped exactly once, even on a mismatch
    if (s_axi_bvalid && s_axi_bready) begin
      `CHK({s_axi_bresp, 32'h0}, exp_q.pop_front())
    end
    if (s_axi_rvalid && s_axi_rready) begin
      `CHK({s_axi_rresp, s_axi_rdata}, exp_q.pop_front())
    end
  end
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // Hang guard, well above the ~1200 cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] a, b, q;              // q: accumulator left by last pass
    logic        p, tk;
    int          n;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, wait_timeout, ext_alarm, dev_error, pos_error} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CBU_REG_ACC, CBU_ACC_RST, CBU_RESP_OKAY);
    rd(CBU_REG_IRQMSK, {28'h0, CBU_MASK_RST}, CBU_RESP_OKAY);
    rd(8'h40, 32'h0, CBU_RESP_SLVERR);
    wr(8'h40, 32'h1, CBU_RESP_SLVERR);
    cbu_prog_host_i.put(8'h10, CBU_OP_UBR, 8'h00, 32'h10);
    cbu_prog_host_i.put(8'h20, CBU_OP_UBR, 8'h00, 32'h20);
    q = CBU_ACC_RST;
    // Pass 0: operands differ, errors low; pass 1: equal, errors high
    for (int i = 0; i < 26; i++) begin
      p = (i >= 13);
      a = rnd();
      b = p ? a : rnd();
      tk = taken(i % 13, a, b, p);
      wr(CBU_REG_CTRL, 32'h2, CBU_RESP_OKAY);
      wr(CBU_REG_ERRCLR, 32'h1, CBU_RESP_OKAY);
      ext_alarm <= p;
      dev_error <= p;
      pos_error <= p;
      wait_timeout <= p;
      @(posedge aclk);
      wait_timeout <= 1'b0;
      // Odd passes reach a by subtracting from the old accumulator
      cbu_prog_host_i.put(8'h00, CBU_OP_ARITH,
                          i[0] ? CBU_ARITH_SUB : CBU_ARITH_LOAD,
                          i[0] ? q - a : a);
      cbu_prog_host_i.put(8'h01, CBU_OP_TEST, 8'h00, b);
      cbu_prog_host_i.put(8'h02, CBU_OP_CBR, 8'(i % 13), 32'h10);
      cbu_prog_host_i.put(8'h03, CBU_OP_UBR, 8'h00, 32'h20);
      wr(CBU_REG_CTRL, 32'h1, CBU_RESP_OKAY);
      n = 0;
      while (pc !== 8'h10 && pc !== 8'h20 && n < 100) begin
        @(posedge aclk);
        n++;
      end
      `CHK(accu, a)
      `CHK(running, 1'b1)
      wr(CBU_REG_CTRL, 32'h0, CBU_RESP_OKAY);
      `CHK(running, 1'b0)
      rd(CBU_REG_PC, {24'h0, tk ? 8'h10 : 8'h20},
         CBU_RESP_OKAY);
      rd(CBU_REG_ACC, a, CBU_RESP_OKAY);
      q = a;
      rd(CBU_REG_FLAGS, {28'h0, p, $signed(a) > $signed(b), a == b, a == b},
         CBU_RESP_OKAY);
      $display("Branch test code %0d pass %0d done", i % 13, p);
    end
    rd(CBU_REG_IRQST, 32'hf, CBU_RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(CBU_REG_IRQMSK, 32'hf, CBU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(CBU_REG_IRQST, 32'hf, CBU_RESP_OKAY);
    rd(CBU_REG_IRQST, 32'h0, CBU_RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0)
    $display("Interrupt test done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
